/* File: hdl/pbc_pkg.sv */
// ----------------------------------------------------------------
// management register space constants
// ----------------------------------------------------------------
package pbc_pkg;

    // register numbers (5-bit clause 22 address field)
    localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] REG_LAST = 5'h1F;
    localparam logic [4:0] REG_VENDOR_FIRST = 5'h10;

    // basic control bit positions
    localparam int BIT_RESET = 15;
    localparam int BIT_LOOPBACK = 14;
    localparam int BIT_SPEED = 13;
    localparam int BIT_ANEG_EN = 12;
    localparam int BIT_POWER_DOWN = 11;
    localparam int BIT_ISOLATE = 10;
    localparam int BIT_ANEG_RESTART = 9;
    localparam int BIT_DUPLEX = 8;
    localparam int BIT_COL_TEST = 7;

    // reset value of the non-strapped fields, and fixed read-back values
    localparam logic CTRL_RST_VAL = 1'b0;
    localparam logic [6:0] RSVD_READ_VAL = 7'h00;
    localparam logic [15:0] UNMAPPED_READ_VAL = 16'h0000;

    // frame opcodes and field lengths
    localparam logic [1:0] OP_WRITE = 2'b01;
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [4:0] HDR_BITS = 5'h0D;   // start '1', op, phy address, register
    localparam logic [4:0] TA_LAST = 5'h01;
    localparam logic [4:0] DATA_LAST = 5'h0F;

    // strap vector layout
    localparam int STRAP_W = 9;
    localparam int STRAP_ANEG = 0;
    localparam int STRAP_ISO = 1;
    localparam int STRAP_SPEED = 2;
    localparam int STRAP_DUPLEX = 3;
    localparam int STRAP_ADDR_LO = 4;

    // cycles a reset waits before catching straps (covers the two sync stages)
    localparam logic [1:0] RELATCH_CYC = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR = 2'b01,
        ST_TA = 2'b10,
        ST_DATA = 2'b11
    } pbc_state_t;

endpackage : pbc_pkg

/* File: hdl/pbc_basic_control.sv */
`timescale 1ns/100ps

module pbc_basic_control import pbc_pkg::*; (
    input wire logic ref_clk_i,                // 100 MHz core clock
    input wire logic rst_i,                    // async reset, active high
    input wire logic mdc_i,                    // management clock pin
    input wire logic mdio_i,                   // management data pin, input side
    output logic mdio_o,                       // management data drive value
    output logic mdio_oe_n_o,                  // low while this end drives the pin
    input wire logic autoneg_enable_strap_i,   // strap: autoneg enable default
    input wire logic isolate_strap_i,          // strap: isolate default
    input wire logic speed_strap_i,            // strap: speed default
    input wire logic duplex_strap_i,           // strap: duplex, inverted into reg
    input wire logic [4:0] phy_addr_strap_i,   // strap: management address
    input wire logic an_speed_100_i,           // negotiated speed from autoneg logic
    input wire logic an_full_duplex_i,         // negotiated duplex from autoneg logic
    output logic soft_reset_o,                 // high while a reset is in progress
    output logic an_restart_o,                 // one-cycle autoneg restart pulse
    output logic autoneg_enable_o,             // autoneg running
    output logic speed_100_o,                  // effective speed, 1 = 100 Mbps
    output logic full_duplex_o,                // effective duplex, 1 = full
    output logic loopback_o,                   // loopback mode
    output logic power_down_o,                 // power-down mode
    output logic isolate_o,                    // media-independent side isolated
    output logic col_test_o                    // collision signal test
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic mdc_s1;
        logic mdc_s2;
        logic mdc_s3;
        logic mdio_s1;
        logic mdio_s2;
        logic [STRAP_W-1:0] strap_s1;
        logic [STRAP_W-1:0] strap_s2;
        pbc_state_t state;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic [4:0] addr;
        logic rd;
        logic mine;
        logic mdio;
        logic mdio_oe_n;
        logic [4:0] phy_addr;
        logic [1:0] relatch;
        logic sreset;
        logic loopback;
        logic speed;
        logic aneg;
        logic pdown;
        logic iso;
        logic duplex;
        logic col;
        logic an_restart;
    } pbc_regs_t;

    localparam pbc_regs_t REGS_RST = '{
        mdc_s1: 1'b0, mdc_s2: 1'b0, mdc_s3: 1'b0, mdio_s1: 1'b1, mdio_s2: 1'b1,
        strap_s1: '0, strap_s2: '0, state: ST_IDLE, cnt: '0, sh: '0, addr: '0,
        rd: 1'b0, mine: 1'b0, mdio: 1'b1, mdio_oe_n: 1'b1, phy_addr: '0,
        relatch: RELATCH_CYC, sreset: 1'b1, loopback: CTRL_RST_VAL,
        speed: CTRL_RST_VAL, aneg: CTRL_RST_VAL, pdown: CTRL_RST_VAL,
        iso: CTRL_RST_VAL, duplex: CTRL_RST_VAL, col: CTRL_RST_VAL,
        an_restart: 1'b0
    };

    pbc_regs_t q;
    pbc_regs_t d;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // any of the 32 addresses is legal; only basic control is held here
    function automatic logic is_ctrl(input logic [4:0] a);
        is_ctrl = (a == REG_BASIC_CONTROL);
    endfunction : is_ctrl

    // unmapped standard and vendor registers read back zero
    function automatic logic [15:0] read_word(input logic [4:0] a, input pbc_regs_t r);
        read_word = UNMAPPED_READ_VAL;
        if (is_ctrl(a)) begin
            read_word = {r.sreset, r.loopback, r.speed, r.aneg, r.pdown, r.iso,
                         1'b0, r.duplex, r.col, RSVD_READ_VAL};
        end
    endfunction : read_word

    logic rise;
    logic [12:0] hdr;
    logic [15:0] wr;
    logic [15:0] rdw;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.an_restart = 1'b0;
        // two-stage synchronisers; stage one feeds stage two only
        d.mdc_s1 = mdc_i;
        d.mdc_s2 = q.mdc_s1;
        d.mdc_s3 = q.mdc_s2;
        d.mdio_s1 = mdio_i;
        d.mdio_s2 = q.mdio_s1;
        d.strap_s1 = {phy_addr_strap_i, duplex_strap_i, speed_strap_i,
                      isolate_strap_i, autoneg_enable_strap_i};
        d.strap_s2 = q.strap_s1;
        rise = q.mdc_s2 & ~q.mdc_s3;
        hdr = {q.sh[11:0], q.mdio_s2};
        wr = {q.sh[14:0], q.mdio_s2};
        rdw = read_word(q.addr, q);

        // strap catch: waits for the synchronisers to settle after any reset
        if (q.relatch != 2'h0) begin
            d.relatch = q.relatch - 2'h1;
            if (q.relatch == 2'h1) begin
                d.sreset = 1'b0;
                d.loopback = CTRL_RST_VAL;
                d.pdown = CTRL_RST_VAL;
                d.col = CTRL_RST_VAL;
                d.aneg = q.strap_s2[STRAP_ANEG];
                d.iso = q.strap_s2[STRAP_ISO];
                d.speed = q.strap_s2[STRAP_SPEED];
                d.duplex = ~q.strap_s2[STRAP_DUPLEX];
                d.phy_addr = q.strap_s2[STRAP_ADDR_LO +: 5];
            end
        end

        // serial frame engine, one step per synchronised mdc rising edge
        if (rise) begin
            case (q.state)
                ST_IDLE: begin
                    d.mdio_oe_n = 1'b1;
                    d.cnt = '0;
                    if (!q.mdio_s2) begin
                        d.state = ST_HDR;   // first start bit; preamble optional
                    end
                end
                ST_HDR: begin
                    d.sh = wr;
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == HDR_BITS - 5'h01) begin
                        d.rd = (hdr[11:10] == OP_READ);
                        d.mine = hdr[12] && (hdr[9:5] == q.phy_addr) &&
                                 (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE);
                        d.addr = hdr[4:0];
                        d.state = ST_TA;
                        d.cnt = '0;
                    end
                end
                ST_TA: begin
                    d.cnt = q.cnt + 5'h01;
                    if (q.mine && q.rd) begin
                        d.mdio_oe_n = 1'b0;   // drive turnaround zero, then data
                        d.mdio = 1'b0;
                    end
                    if (q.cnt == TA_LAST) begin
                        d.state = ST_DATA;
                        d.cnt = '0;
                        d.sh = rdw;
                        d.mdio = (q.mine && q.rd) ? rdw[15] : 1'b1;
                    end
                end
                ST_DATA: begin
                    d.cnt = q.cnt + 5'h01;
                    d.sh = q.rd ? {q.sh[14:0], 1'b0} : wr;
                    d.mdio = q.rd ? q.sh[14] : 1'b1;
                    if (q.cnt == DATA_LAST) begin
                        d.state = ST_IDLE;
                        d.mdio_oe_n = 1'b1;
                        d.mdio = 1'b1;
                        if (q.mine && !q.rd && is_ctrl(q.addr)) begin
                            if (wr[BIT_RESET] && q.pdown) begin
                                // first reset write only wakes from power-down
                                d.pdown = 1'b0;
                            end else if (wr[BIT_RESET]) begin
                                d.sreset = 1'b1;
                                d.relatch = RELATCH_CYC;
                            end else begin
                                d.loopback = wr[BIT_LOOPBACK];
                                d.speed = wr[BIT_SPEED];
                                d.aneg = wr[BIT_ANEG_EN];
                                d.pdown = wr[BIT_POWER_DOWN];
                                d.iso = wr[BIT_ISOLATE];
                                d.duplex = wr[BIT_DUPLEX];
                                d.col = wr[BIT_COL_TEST];
                                d.an_restart = wr[BIT_ANEG_RESTART];
                            end
                        end
                    end
                end
                default: begin
                    d.state = ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // negotiated result wins over the manual bits while autoneg is on
    assign speed_100_o = q.aneg ? an_speed_100_i : q.speed;
    assign full_duplex_o = q.aneg ? an_full_duplex_i : q.duplex;
    assign mdio_o = q.mdio;
    assign mdio_oe_n_o = q.mdio_oe_n;
    assign soft_reset_o = q.sreset;
    assign an_restart_o = q.an_restart;
    assign autoneg_enable_o = q.aneg;
    assign loopback_o = q.loopback;
    assign power_down_o = q.pdown;
    assign isolate_o = q.iso;
    assign col_test_o = q.col;

endmodule : pbc_basic_control

/* File: sim/pbc_mdio_master.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// station manager model: mdc stands still between frames
// ----------------------------------------------------------------
module pbc_mdio_master (
    input wire logic clk_i,        // bench clock, drives on its falling edge
    input wire logic wire_i,       // resolved mdio level
    output logic mdc_o,            // management clock
    output logic mdio_o,           // drive value
    output logic oe_o,             // 1 while this end drives mdio
    output logic rd_v_o,           // read word valid, one clock
    output logic [15:0] rd_d_o     // read word
);
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        oe_o = 1'b0;
        rd_v_o = 1'b0;
        rd_d_o = 16'h0000;
    end

    // one whole frame; mdc low 6 and high 5 clocks, above the 4-clock minimum
    task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd);
        logic [31:0] f;
        f = {2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
        for (int k = 0; k < 32; k++) begin
            @(negedge clk_i);
            oe_o <= !(rd && k >= 14);   // reads release the line from turnaround on
            mdio_o <= f[31-k];
            repeat (5) @(negedge clk_i);
            if (k >= 16) rd_d_o[31-k] <= wire_i;
            mdc_o <= 1'b1;
            repeat (5) @(negedge clk_i);
            mdc_o <= 1'b0;
        end
        oe_o <= 1'b0;
        rd_v_o <= rd;
        @(negedge clk_i);
        rd_v_o <= 1'b0;
    endtask : frame
endmodule : pbc_mdio_master

/* File: sim/pbc_basic_control_sva.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// basic control register checks
// ----------------------------------------------------------------
module pbc_basic_control_sva (
    input wire logic ref_clk_i,              // core clock
    input wire logic rst_i,                  // async reset
    input wire logic mdio_o,                 // data drive value
    input wire logic mdio_oe_n_o,            // drive enable, low active
    input wire logic autoneg_enable_strap_i, // strap
    input wire logic isolate_strap_i,        // strap
    input wire logic an_speed_100_i,         // negotiated speed
    input wire logic an_full_duplex_i,       // negotiated duplex
    input wire logic soft_reset_o,           // reset in progress
    input wire logic an_restart_o,           // restart pulse
    input wire logic autoneg_enable_o,       // autoneg on
    input wire logic speed_100_o,            // effective speed
    input wire logic full_duplex_o,          // effective duplex
    input wire logic loopback_o,             // loopback
    input wire logic power_down_o,           // power-down
    input wire logic isolate_o,              // isolate
    input wire logic col_test_o              // collision test
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    // strap catch ends a few clocks after release; a read drives for 17 mdc periods
    sequence s_catch;
        soft_reset_o [*2] ##[1:2] !soft_reset_o;
    endsequence
    sequence s_drive;
        !mdio_oe_n_o [*8] ##[1:400] mdio_oe_n_o;
    endsequence

    a_reset_catch: assert property ($fell(rst_i) |-> s_catch)
        else $error("strap catch not done in time");
    a_strap_load: assert property ($fell(soft_reset_o) |-> isolate_o == isolate_strap_i && autoneg_enable_o == autoneg_enable_strap_i)
        else $error("strap fields not loaded");
    a_soft_clear: assert property ($fell(soft_reset_o) |-> !(loopback_o || power_down_o || col_test_o))
        else $error("modes not cleared by reset");
    a_restart_pulse: assert property (an_restart_o |=> !an_restart_o)
        else $error("restart pulse too long");
    a_speed_mux: assert property (autoneg_enable_o |-> speed_100_o == an_speed_100_i)
        else $error("speed not from autoneg");
    a_duplex_mux: assert property (autoneg_enable_o |-> full_duplex_o == an_full_duplex_i)
        else $error("duplex not from autoneg");
    a_ta_zero: assert property ($fell(mdio_oe_n_o) |-> !mdio_o)
        else $error("turnaround not driven low");
    a_drive_len: assert property ($fell(mdio_oe_n_o) |-> s_drive)
        else $error("read drive length wrong");
endmodule : pbc_basic_control_sva

bind pbc_basic_control pbc_basic_control_sva pbc_basic_control_sva_inst (.ref_clk_i, .rst_i,
    .mdio_o, .mdio_oe_n_o, .autoneg_enable_strap_i, .isolate_strap_i, .an_speed_100_i,
    .an_full_duplex_i, .soft_reset_o, .an_restart_o, .autoneg_enable_o, .speed_100_o,
    .full_duplex_o, .loopback_o, .power_down_o, .isolate_o, .col_test_o);

/* File: sim/test_pbc_basic_control.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// bench: reads queue their expected word, a watcher compares
// ----------------------------------------------------------------
module test_pbc_basic_control;
    logic clk, rst, mdc, m_mdio, m_oe, d_mdio, d_oe_n, rd_v, mdio_w;
    logic s_an, s_iso, s_spd, s_dup, an_spd, an_dup, lb, spd, an_en, pd, iso, fd, col;
    logic [4:0] s_pa;
    logic [15:0] rd_d, e, v;
    logic [15:0] exp_q[$];
    logic an_rs;
    int rs_n = 0;
    int checks = 0;
    int bad_count = 0;

    // pull-up on mdio when nobody drives
    assign mdio_w = !d_oe_n ? d_mdio : (m_oe ? m_mdio : 1'b1);

    pbc_basic_control pbc_basic_control_inst (.ref_clk_i(clk), .rst_i(rst), .mdc_i(mdc),
        .mdio_i(mdio_w), .mdio_o(d_mdio), .mdio_oe_n_o(d_oe_n), .autoneg_enable_strap_i(s_an),
        .isolate_strap_i(s_iso), .speed_strap_i(s_spd), .duplex_strap_i(s_dup),
        .phy_addr_strap_i(s_pa), .an_speed_100_i(an_spd), .an_full_duplex_i(an_dup),
        .soft_reset_o(), .an_restart_o(an_rs), .autoneg_enable_o(an_en), .speed_100_o(spd),
        .full_duplex_o(fd), .loopback_o(lb), .power_down_o(pd), .isolate_o(iso),
        .col_test_o(col));
    pbc_mdio_master pbc_mdio_master_inst (.clk_i(clk), .wire_i(mdio_w), .mdc_o(mdc),
        .mdio_o(m_mdio), .oe_o(m_oe), .rd_v_o(rd_v), .rd_d_o(rd_d));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    function automatic logic [15:0] img();
        return {2'b00, s_spd, s_an, 1'b0, s_iso, 1'b0, ~s_dup, 8'h00};
    endfunction : img

    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] x);
        exp_q.push_back(x);
        pbc_mdio_master_inst.frame(1'b1, pa, ra, 16'h0000);
    endtask : rd

    // writes land a few clocks after the last data bit
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        pbc_mdio_master_inst.frame(1'b0, s_pa, ra, d);
        repeat (8) @(negedge clk);
    endtask : wr

    // autoneg overrides the manual speed and duplex bits at the outputs
    task automatic outs();
        logic [15:0] g, x;
        g = {9'h000, lb, spd, an_en, pd, iso, fd, col};
        x = {9'h000, e[14], e[12] ? an_spd : e[13], e[12], e[11], e[10], e[12] ? an_dup : e[8], e[7]};
        chk(g, x);
    endtask : outs

    // watcher: every read word is matched against the oldest note
    always @(posedge clk) begin
        if (rd_v === 1'b1) chk(rd_d, exp_q.pop_front());
    end

    // restart pulses are counted so a missing or stray pulse shows up
    always @(posedge clk) begin
        if (an_rs === 1'b1) rs_n++;
    end

    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        void'($urandom(32'h4847));
        {s_an, s_iso, s_spd, s_dup, s_pa, an_spd, an_dup} = 11'($urandom);
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        e = img();
        rd(s_pa, 5'h00, e);
        outs();
        $display("test strap defaults done");
        for (int k = 0; k < 4; k++) begin
            v = 16'($urandom) & 16'h77FF;
            v[12] = k[0];
            v[9] = k[1];
            {an_spd, an_dup} = 2'($urandom);
            wr(5'h00, v);
            e = v & 16'h7580;
            rd(s_pa, 5'h00, e);
            outs();
        end
        chk(16'(rs_n), 16'h0002);
        $display("test mode writes done");
        v = 16'($urandom % 31 + 1);
        rd(s_pa, v[4:0], 16'h0000);
        wr(v[4:0], 16'hFFFF);
        rd(s_pa, 5'h00, e);
        rd(s_pa ^ 5'h01, 5'h00, 16'hFFFF);
        $display("test address decode done");
        wr(5'h00, e | 16'h0800);
        e = e | 16'h0800;
        outs();
        wr(5'h00, 16'hC000);
        e = e & 16'hF7FF;
        rd(s_pa, 5'h00, e);
        {s_an, s_iso, s_spd, s_dup} = 4'($urandom);
        wr(5'h00, 16'h8000);
        e = img();
        rd(s_pa, 5'h00, e);
        outs();
        chk(16'(rs_n), 16'h0002);
        $display("test power-down exit done");
        final_report();
    end
endmodule : test_pbc_basic_control
